// *** include/sfp_pkg.sv ***
// Shared constants and types for the serial flash pin control block.
// Assumes one core clock; pin inputs are asynchronous to it.
package sfp_pkg;
    localparam int WORD_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] STEP_SINGLE = 3'h1;
    localparam logic [2:0] STEP_DUAL = 3'h2;
    localparam logic [7:0] IDLE_FILL = 8'hff;

    // Pin samples travel together through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
    } sfp_pins_t;

    // Chip select reads as low at reset so a low pin is no falling edge
    localparam sfp_pins_t PINS_RST = 5'h03;

    typedef enum logic [1:0] {
        SFP_IDLE = 2'b00,
        SFP_ACTIVE = 2'b01,
        SFP_PAUSED = 2'b10
    } sfp_mode_t;

    typedef struct packed {
        sfp_pins_t s1;
        sfp_pins_t s2;
        sfp_pins_t s3;
        sfp_mode_t mode;
        logic armed;
        logic [2:0] in_cnt;
        logic [7:0] in_sh;
        logic pend;
        logic [7:0] pend_data;
        logic overrun;
        logic [2:0] out_cnt;
        logic [7:0] out_sh;
        logic out_live;
        logic dual_r;
        logic io0_o;
        logic io1_o;
        logic oe0_n;
        logic oe1_n;
        logic wp_lock;
    } sfp_state_t;

    localparam sfp_state_t STATE_RST = '{
        s1: PINS_RST, s2: PINS_RST, s3: PINS_RST, mode: SFP_IDLE,
        armed: 1'b0, in_cnt: 3'h0, in_sh: 8'h00, pend: 1'b0,
        pend_data: 8'h00, overrun: 1'b0, out_cnt: 3'h0, out_sh: 8'h00,
        out_live: 1'b0, dual_r: 1'b0, io0_o: 1'b0, io1_o: 1'b0,
        oe0_n: 1'b1, oe1_n: 1'b1, wp_lock: 1'b0};
endpackage : sfp_pkg

// *** rtl/sfp_top.sv ***
// Pin-level control of a serial flash SPI port plus its receive FIFO.
// Assumes pins are asynchronous to core_clk and sck is far slower.
`timescale 1ns/1ps

module sfp_fifo #(
    parameter int W = sfp_pkg::WORD_W,
    parameter int D = sfp_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } sfp_fifo_t;

    sfp_fifo_t st;
    sfp_fifo_t next_st;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] sfp_wrap(input logic [AW-1:0] p);
        sfp_wrap = (p == LAST) ? '0 : p + 1'b1;
    endfunction : sfp_wrap

    // Honest flags straight from the count
    assign in_ready = (st.cnt != FULL);
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = sfp_wrap(st.wr);
        end
        if (pop) begin
            next_st.rd = sfp_wrap(st.rd);
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Count never passes the depth; a wrap here would hand out stale words
    fifo_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st.cnt <= FULL)
        else $error("receive buffer count beyond depth");
endmodule : sfp_fifo

module sfp_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic io0_in,
    output logic io0_out,
    output logic io0_oe_n,
    output logic io1_out,
    output logic io1_oe_n,
    input wire logic io2_in,
    input wire logic io3_in,
    input wire logic tx_enable,
    input wire logic dual_read,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic quad_lane_enable,
    input wire logic [1:0] status_lock_bits,
    input wire logic protect_level_bit2,
    input wire logic protect_level_bit1,
    input wire logic protect_level_bit0,
    output logic status_write_ok,
    output logic array_hw_locked,
    output logic selected,
    output logic paused,
    output logic armed
);
    sfp_pkg::sfp_state_t st;
    sfp_pkg::sfp_state_t next_st;
    sfp_pkg::sfp_pins_t pins;
    logic cs_s;
    logic sck_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic hold_fall;
    logic hold_rise;
    logic active;
    logic in_step;
    logic out_step;
    logic fifo_ready;
    logic [7:0] word;
    logic [7:0] in_next;

    function automatic logic sfp_edge(input logic now, input logic was, input logic up);
        sfp_edge = up ? (now & ~was) : (~now & was);
    endfunction : sfp_edge

    // Edges come from the second and third stages; stage one feeds stage two only
    assign pins = '{cs_n: cs_n, sck: sck, si: io0_in, wp_n: io2_in, hold_n: io3_in};
    assign cs_s = st.s2.cs_n;
    assign sck_s = st.s2.sck;
    assign sck_rise = sfp_edge(st.s2.sck, st.s3.sck, 1'b1);
    assign sck_fall = sfp_edge(st.s2.sck, st.s3.sck, 1'b0);
    assign cs_fall = sfp_edge(st.s2.cs_n, st.s3.cs_n, 1'b0);
    assign hold_fall = sfp_edge(st.s2.hold_n, st.s3.hold_n, 1'b0);
    assign hold_rise = sfp_edge(st.s2.hold_n, st.s3.hold_n, 1'b1);

    // A pause that begins this cycle suppresses the shift
    assign active = (st.mode == sfp_pkg::SFP_ACTIVE) && !cs_s;
    assign in_step = active && sck_rise && !st.dual_r;
    assign out_step = active && sck_fall && tx_enable && !hold_fall;
    assign tx_ready = out_step && (st.out_cnt == 3'h0);
    assign word = (st.out_cnt != 3'h0) ? st.out_sh : (tx_valid ? tx_data : sfp_pkg::IDLE_FILL);
    assign in_next = {st.in_sh[6:0], st.s2.si};

    sfp_fifo #(
        .W(sfp_pkg::WORD_W),
        .D(sfp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_data(st.pend_data),
        .in_valid(st.pend),
        .in_ready(fifo_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // Whole interface state: one copy built here, registered below
    always_comb begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Pin low is asserted; lost when the pin serves as a data lane
        next_st.wp_lock = !st.s2.wp_n && status_lock_bits[0] && !quad_lane_enable;
        if (st.pend && fifo_ready) begin
            next_st.pend = 1'b0;
        end
        case (st.mode)
            sfp_pkg::SFP_IDLE: begin
                // Only a real falling edge arms decoding
                if (cs_fall) begin
                    next_st.mode = sfp_pkg::SFP_ACTIVE;
                    next_st.armed = 1'b1;
                    next_st.overrun = 1'b0;
                end
            end
            sfp_pkg::SFP_ACTIVE: begin
                next_st.dual_r = dual_read;
                if (hold_fall && !sck_s && !cs_s) begin
                    next_st.mode = sfp_pkg::SFP_PAUSED;
                end
                if (in_step) begin
                    next_st.in_sh = in_next;
                    next_st.in_cnt = st.in_cnt + 1'b1;
                    if (st.in_cnt == sfp_pkg::BIT_LAST) begin
                        // A byte still waiting on a full FIFO is overwritten
                        if (st.pend && !fifo_ready) begin
                            next_st.overrun = 1'b1;
                        end
                        next_st.pend = 1'b1;
                        next_st.pend_data = in_next;
                    end
                end
                if (!tx_enable) begin
                    next_st.out_live = 1'b0;
                    next_st.out_cnt = 3'h0;
                end else if (out_step) begin
                    next_st.out_live = 1'b1;
                    next_st.io1_o = word[7];
                    if (st.dual_r) begin
                        next_st.io0_o = word[6];
                        next_st.out_sh = {word[5:0], 2'b00};
                        next_st.out_cnt = st.out_cnt + sfp_pkg::STEP_DUAL;
                    end else begin
                        next_st.out_sh = {word[6:0], 1'b0};
                        next_st.out_cnt = st.out_cnt + sfp_pkg::STEP_SINGLE;
                    end
                end
            end
            sfp_pkg::SFP_PAUSED: begin
                // Clock and input ignored; counters and shifters kept
                if (hold_rise && !sck_s) begin
                    next_st.mode = sfp_pkg::SFP_ACTIVE;
                end
            end
            default: begin
                next_st.mode = sfp_pkg::SFP_IDLE;
            end
        endcase
        // Deselect wins over everything, including a pause in progress
        if (cs_s) begin
            next_st.mode = sfp_pkg::SFP_IDLE;
            next_st.in_cnt = 3'h0;
            next_st.out_cnt = 3'h0;
            next_st.out_live = 1'b0;
            next_st.dual_r = 1'b0;
        end
        // Enables follow the next mode so they are never a cycle late
        next_st.oe1_n = !(next_st.mode == sfp_pkg::SFP_ACTIVE && next_st.out_live);
        next_st.oe0_n = !(next_st.mode == sfp_pkg::SFP_ACTIVE && next_st.out_live
            && next_st.dual_r);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= sfp_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign io0_out = st.io0_o;
    assign io1_out = st.io1_o;
    assign io0_oe_n = st.oe0_n;
    assign io1_oe_n = st.oe1_n;
    assign rx_overrun = st.overrun;
    assign status_write_ok = !st.wp_lock;
    assign array_hw_locked = st.wp_lock
        && (protect_level_bit2 || protect_level_bit1 || protect_level_bit0);
    assign selected = (st.mode != sfp_pkg::SFP_IDLE);
    assign paused = (st.mode == sfp_pkg::SFP_PAUSED);
    assign armed = st.armed;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence hold_in_s;
        hold_fall && !sck_s && !cs_s && st.mode == sfp_pkg::SFP_ACTIVE;
    endsequence

    sequence hold_out_s;
        paused && hold_rise && !sck_s && !cs_s;
    endsequence

    desel_noshift_a: assert property (cs_s |=> $stable(st.in_sh))
        else $error("input shifted while deselected");
    out_on_fall_a: assert property ($changed(st.io1_o) |-> $past(sck_fall))
        else $error("output changed without falling clock");
    dual_both_a: assert property (!io1_oe_n && st.dual_r |-> !io0_oe_n)
        else $error("dual read drives one pin only");
    desel_float_a: assert property (cs_s |=> io0_oe_n && io1_oe_n)
        else $error("pin driven while deselected");
    wp_blocks_a: assert property (!st.s2.wp_n && status_lock_bits[0]
        && !quad_lane_enable |=> !status_write_ok)
        else $error("status write allowed while protected");
    wp_high_a: assert property (st.s2.wp_n |=> status_write_ok)
        else $error("protect asserted with pin high");
    quad_frees_a: assert property (quad_lane_enable |=> !array_hw_locked)
        else $error("protect active in quad mode");
    pause_cs_a: assert property ($rose(paused) |-> $past(!cs_s))
        else $error("pause entered while deselected");
    pause_entry_a: assert property (hold_in_s |=> paused)
        else $error("pause not entered");
    pause_sck_a: assert property (hold_fall && sck_s |=> !$rose(paused))
        else $error("pause entered with clock high");
    pause_exit_a: assert property (hold_out_s |=> st.mode == sfp_pkg::SFP_ACTIVE)
        else $error("pause not left");
    pause_abort_a: assert property (paused && cs_s
        |=> st.mode == sfp_pkg::SFP_IDLE && st.in_cnt == 3'h0)
        else $error("deselect did not reset paused logic");
    pause_hold_a: assert property (paused && !st.s2.hold_n && !st.s1.hold_n
        && !cs_s && !st.s1.cs_n |=> paused [*2])
        else $error("pause left while hold low");
    sample_rise_a: assert property ($changed(st.in_cnt) && !$past(cs_s)
        |-> $past(sck_rise))
        else $error("input sampled off rising edge");
    unarmed_quiet_a: assert property (!st.armed |=> $stable(st.in_cnt))
        else $error("decode before first select edge");
    paused_quiet_a: assert property (paused ##1 paused
        |-> io1_oe_n && $stable(st.in_sh) && $stable(st.out_sh))
        else $error("activity while paused");

    // Second lane, byte hand-off, arming and pin float; two of them start from a named step
    sequence dual_fall_s;
        out_step && st.dual_r;
    endsequence
    sequence byte_end_s;
        in_step && st.in_cnt == sfp_pkg::BIT_LAST;
    endsequence

    io0_on_fall_a: assert property ($changed(st.io0_o) |-> $past(sck_fall))
        else $error("second lane changed without falling clock");
    dual_two_bits_a: assert property (dual_fall_s
        |=> st.out_cnt == $past(st.out_cnt) + sfp_pkg::STEP_DUAL)
        else $error("dual read did not take two bits");
    dual_no_input_a: assert property (st.dual_r && !cs_s |=> $stable(st.in_cnt))
        else $error("input shifted during dual read");
    first_arm_a: assert property ($rose(st.armed) |-> $past(cs_fall))
        else $error("decoding armed without a select edge");
    pause_float_a: assert property (paused |-> io0_oe_n && io1_oe_n)
        else $error("pin driven while paused");
    byte_pend_a: assert property (byte_end_s
        |=> st.pend && st.pend_data == $past(in_next))
        else $error("completed byte not queued");
    overrun_hold_a: assert property (rx_overrun && !cs_fall |=> rx_overrun)
        else $error("overrun flag lost inside a frame");
    idle_quiet_a: assert property (!selected |-> io0_oe_n && io1_oe_n)
        else $error("pin driven while idle");
endmodule : sfp_top

// *** sim/sfp_host.sv ***
// SPI host model driving chip select, serial clock, serial input and hold.
// Assumes the bench clock paces it; pins change on the core clock's falling edge.
`timescale 1ns/1ps
module sfp_host (
    input wire logic core_clk,
    input wire logic io0,
    input wire logic io1,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    // Mode 3 idle: deselected, clock parked high, hold released
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // Half of the 160 ns link period
    task automatic half();
        repeat (10) @(negedge core_clk);
    endtask : half
    // Clock parked at both select edges; a released input shows its inverse
    task automatic sel(input logic on);
        sck = 1'b1;
        half();
        cs_n = !on;
        si = !si;
        half();
    endtask : sel
    // One bit: data set with the fall, both lanes sampled at the rise
    task automatic bit2(input logic d, output logic [1:0] q);
        sck = 1'b0;
        si = d;
        half();
        sck = 1'b1;
        q = {io1, io0};
        half();
    endtask : bit2
    // One byte MSB first, the serial output collected alongside
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        logic [1:0] b;
        for (int i = 7; i >= 0; i--) begin
            bit2(d[i], b);
            q[i] = b[1];
        end
    endtask : byte_io
    // Clock and hold levels; a well-behaved caller keeps the clock low at hold edges
    task automatic pins(input logic s, input logic h);
        sck = s;
        hold_n = h;
        half();
    endtask : pins
endmodule : sfp_host

// *** sim/sfp_top_test.sv ***
// Self-checking bench for the serial flash pin control block and its FIFO.
// Assumes sfp_host drives the link pins; other inputs change at the falling edge.
`timescale 1ns/1ps
module sfp_top_test;
    logic core_clk = 1'b0, resetn = 1'b0, tx_enable = 1'b0, dual_read = 1'b0;
    logic tx_valid = 1'b0, rx_ready = 1'b0, wp_n = 1'b1, quad = 1'b0, pl1 = 1'b0;
    logic pl2 = 1'b0, pl0 = 1'b0;
    logic [1:0] lock = 2'h0;
    logic [7:0] tx_data = 8'h00;
    logic cs_n, sck, si, hold_n, io0, io1, io0_out, io0_oe_n, io1_out, io1_oe_n;
    logic tx_ready, rx_valid, rx_overrun, wr_ok, hw_lock, selected, paused, armed;
    logic [7:0] rx_data;
    int mismatches = 0;
    int compares = 0;
    int takes = 0;
    // The block wins IO0 while it drives; a released IO1 shows the inverse of its last bit
    assign io0 = !io0_oe_n ? io0_out : si;
    assign io1 = !io1_oe_n ? io1_out : !io1_out;
    // Send-side byte loads, sampled away from the edge that launches them
    always @(negedge core_clk) begin
        if (tx_ready === 1'b1) begin
            takes++;
        end
    end
    initial forever #4 core_clk = ~core_clk;
    sfp_top dut_u (
        .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .io0_in(io0),
        .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_out(io1_out), .io1_oe_n(io1_oe_n),
        .io2_in(wp_n), .io3_in(hold_n), .tx_enable(tx_enable), .dual_read(dual_read),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .quad_lane_enable(quad), .status_lock_bits(lock), .protect_level_bit2(pl2),
        .protect_level_bit1(pl1), .protect_level_bit0(pl0), .status_write_ok(wr_ok),
        .array_hw_locked(hw_lock), .selected(selected), .paused(paused), .armed(armed)
    );
    sfp_host host_u (
        .core_clk(core_clk), .io0(io0), .io1(io1), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n)
    );
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic check1(input string what, input logic exp, input logic got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask : check1
    task automatic idle_cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle_cycles
    // Bounded wait for a byte, then a one-cycle pop
    task automatic pop(output logic [7:0] d);
        int n = 0;
        while (rx_valid !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check1("rx valid", 1'b1, rx_valid);
        d = rx_data;
        rx_ready = 1'b1;
        @(negedge core_clk);
        rx_ready = 1'b0;
        @(negedge core_clk);
    endtask : pop
    // Clocking a full byte while deselected must leave nothing behind
    task automatic t_deselect();
        logic [7:0] q;
        check("oe", 8'h03, {6'h00, io1_oe_n, io0_oe_n});
        check1("armed", 1'b0, armed);
        host_u.sel(1'b1);
        check1("armed", 1'b1, armed);
        host_u.sel(1'b0);
        host_u.byte_io(8'hff, q);
        host_u.sel(1'b1);
        host_u.byte_io(8'ha5, q);
        host_u.sel(1'b0);
        pop(q);
        check("rx byte", 8'ha5, q);
        idle_cycles(30);
        check1("rx empty", 1'b0, rx_valid);
        $display("deselect done");
    endtask : t_deselect
    task automatic t_read(input logic dual, input logic [7:0] d);
        logic [7:0] q;
        logic [1:0] b;
        int t0;
        t0 = takes;
        tx_enable = 1'b1;
        tx_valid = 1'b1;
        dual_read = dual;
        tx_data = d;
        host_u.sel(1'b1);
        if (dual) begin
            for (int i = 0; i < 4; i++) begin
                host_u.bit2(1'b0, b);
                q = {q[5:0], b};
            end
        end else begin
            host_u.byte_io(8'h00, q);
        end
        check("drive", {6'h00, !dual, 1'b0}, {6'h00, io0_oe_n, io1_oe_n});
        check("tx byte", d, q);
        host_u.sel(1'b0);
        check("float", 8'h03, {6'h00, io1_oe_n, io0_oe_n});
        check("tx takes", 8'h01, 8'(takes - t0));
        if (dual) begin
            check1("no rx", 1'b0, rx_valid);
        end else begin
            pop(q);
            check("rx zero", 8'h00, q);
        end
        tx_enable = 1'b0;
        tx_valid = 1'b0;
        dual_read = 1'b0;
        $display("read done");
    endtask : t_read
    // Every mix of lock bit, pin level and quad lane enable
    task automatic t_protect();
        logic [2:0] v;
        logic e;
        pl1 = 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            lock = {1'b0, v[2]};
            wp_n = v[1];
            quad = v[0];
            e = v[2] & !v[1] & !v[0];
            idle_cycles(8);
            check("protect", {6'h00, e, !e}, {6'h00, hw_lock, wr_ok});
        end
        // Pin protection on: any protect level bit locks the array
        lock = 2'h1;
        wp_n = 1'b0;
        quad = 1'b0;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            {pl2, pl1, pl0} = v;
            idle_cycles(8);
            check("level lock", {6'h00, |v, 1'b0}, {6'h00, hw_lock, wr_ok});
        end
        wp_n = 1'b1;
        lock = 2'h0;
        {pl2, pl1, pl0} = 3'h0;
        $display("protect done");
    endtask : t_protect
    // Hold edges with the clock high are ignored; a pause keeps the half byte
    task automatic t_pause();
        logic [7:0] q;
        logic [1:0] b;
        q = 8'hc6;
        host_u.sel(1'b1);
        for (int i = 7; i >= 4; i--) host_u.bit2(q[i], b);
        host_u.pins(1'b1, 1'b0);
        check1("hold clk high", 1'b0, paused);
        host_u.pins(1'b0, 1'b0);
        host_u.pins(1'b0, 1'b1);
        host_u.pins(1'b0, 1'b0);
        check("paused", 8'h03, {6'h00, paused, io1_oe_n});
        host_u.pins(1'b1, 1'b0);
        host_u.pins(1'b1, 1'b1);
        check1("still paused", 1'b1, paused);
        host_u.pins(1'b0, 1'b0);
        host_u.pins(1'b0, 1'b1);
        check1("resumed", 1'b0, paused);
        for (int i = 3; i >= 0; i--) host_u.bit2(q[i], b);
        host_u.sel(1'b0);
        pop(q);
        check("held byte", 8'hc6, q);
        $display("pause done");
    endtask : t_pause
    task automatic t_abort();
        logic [7:0] q;
        logic [1:0] b;
        host_u.sel(1'b1);
        host_u.bit2(1'b1, b);
        host_u.pins(1'b0, 1'b1);
        host_u.pins(1'b0, 1'b0);
        check1("paused", 1'b1, paused);
        host_u.sel(1'b0);
        check("abort", 8'h00, {6'h00, paused, selected});
        host_u.pins(1'b0, 1'b1);
        host_u.pins(1'b0, 1'b0);
        check1("deselected hold", 1'b0, paused);
        host_u.pins(1'b1, 1'b1);
        host_u.sel(1'b1);
        host_u.byte_io(8'h5b, q);
        host_u.sel(1'b0);
        pop(q);
        check("after abort", 8'h5b, q);
        $display("abort done");
    endtask : t_abort
    // Ten bytes into a stalled sink: eight buffered, one pending, one overwrites
    task automatic t_fifo();
        logic [7:0] q;
        host_u.sel(1'b1);
        for (int i = 0; i < 10; i++) host_u.byte_io(8'h10 + 8'(i), q);
        host_u.sel(1'b0);
        check1("overrun", 1'b1, rx_overrun);
        for (int i = 0; i < 9; i++) begin
            pop(q);
            check("drain", (i < 8) ? 8'h10 + 8'(i) : 8'h19, q);
        end
        idle_cycles(8);
        check1("drained", 1'b0, rx_valid);
        $display("fifo done");
    endtask : t_fifo
    // Tests take about 3200 cycles; the watchdog allows far more
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        idle_cycles(4);
        t_deselect();
        t_read(1'b0, 8'h3c);
        t_read(1'b1, 8'h96);
        t_protect();
        t_pause();
        t_abort();
        t_fifo();
        summarize();
    end
endmodule : sfp_top_test
